// >>> common/sfb_pkg.sv
package sfb_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_IRQ_FLAGS  = 8'h00;
    localparam logic [7:0] OFS_LEVELS     = 8'h04;
    localparam logic [7:0] OFS_CTRL       = 8'h08;
    localparam logic [7:0] OFS_TX_DATA    = 8'h0c;
    localparam logic [7:0] OFS_RX_DATA    = 8'h10;

    // Bit positions in serial_flash_irq_flags
    localparam int FLG_TX_EMPTY  = 0;
    localparam int FLG_TX_FULL   = 1;
    localparam int FLG_TX_THR    = 2;
    localparam int FLG_RX_THR    = 3;
    localparam int NUM_FLAGS     = 4;

    // Fields of serial_flash_buffer_levels and of the control word
    localparam int CNT_W         = 6;
    localparam int TX_FREE_LSB   = 16;
    localparam int RX_CNT_LSB    = 0;
    localparam int TX_LVL_LSB    = 0;
    localparam int RX_LVL_LSB    = 8;

    // Values after reset
    localparam logic [CNT_W-1:0] TX_LVL_RST = 6'h08;
    localparam logic [CNT_W-1:0] RX_LVL_RST = 6'h00;
    localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 4'h0;

    localparam int DATA_W        = 32;
    localparam int BUF_DEPTH     = 32;

endpackage : sfb_pkg

// >>> verilog/word_ram.sv
`timescale 1ns/1ns
`default_nettype none

module word_ram #(
    parameter int W     = 32,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          mclk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output var  logic [W-1:0]  rdata_o
);

    logic [W-1:0] mem [DEPTH];

    // No reset on storage; read data is registered, old data on collision
    always_ff @(posedge mclk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        rdata_o <= mem[raddr_i];
    end

endmodule : word_ram

`default_nettype wire

// >>> verilog/sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
    parameter int N = 4
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    output var  logic [N-1:0] flags_o
);

    for (genvar k = 0; k < N; k++)
    begin : g_flag
        // Set beats clear so an event in the clear cycle is kept
        always_ff @(posedge mclk_i)
        begin
            if (rst_i)
            begin
                flags_o[k] <= sfb_pkg::FLAGS_RST[k];
            end
            else if (set_i[k])
            begin
                flags_o[k] <= 1'b1;
            end
            else if (clr_i[k])
            begin
                flags_o[k] <= 1'b0;
            end
        end
    end

endmodule : sticky_flags

`default_nettype wire

// >>> verilog/serial_flash_buffer_status.sv
// Operation
// - Transmit threshold flag when free space exceeds level
// - Full flag when no free space
// - Empty flag when buffer holds nothing
// - Writing one clears flag unless its source still holds, zero keeps it
// - Boot mode: receive flag held until read
// - Free transmit words in bits 21:16
// - Buffered receive words in bits 5:0
`timescale 1ns/1ns
`default_nettype none

module serial_flash_buffer_status #(
    parameter int DEPTH  = sfb_pkg::BUF_DEPTH,
    parameter int ADDR_W = 8
) (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    input  wire logic                      boot_xip_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [ADDR_W-1:0]         paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output var  logic [31:0]               prdata_o,
    output var  logic                      pready_o,
    output var  logic                      pslverr_o,
    input  wire logic                      tx_pop_i,
    output var  logic [31:0]               tx_data_o,
    output var  logic                      tx_valid_o,
    input  wire logic                      rx_push_i,
    input  wire logic [31:0]               rx_data_i,
    output var  logic                      rx_ready_o
);

    localparam int CW = sfb_pkg::CNT_W;
    localparam int PW = $clog2(DEPTH);
    localparam int NF = sfb_pkg::NUM_FLAGS;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [CW-1:0] tx_cnt_r;
    logic [CW-1:0] tx_cnt_nxt;
    logic [CW-1:0] rx_cnt_r;
    logic [CW-1:0] rx_cnt_nxt;
    logic [PW-1:0] tx_wr_r;
    logic [PW-1:0] tx_rd_r;
    logic [PW-1:0] tx_rd_nxt;
    logic [PW-1:0] rx_wr_r;
    logic [PW-1:0] rx_rd_r;
    logic [PW-1:0] rx_rd_nxt;
    logic [CW-1:0] tx_free;
    logic [CW-1:0] tx_lvl_r;
    logic [CW-1:0] rx_lvl_r;
    logic          boot_hold_r;
    logic          rx_avail_r;
    logic          rx_take_r;
    logic [31:0]   rx_rdata;
    logic [NF-1:0] flag_q;
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_clr;
    logic          capture;
    logic          fire;
    logic          wr_fire;
    logic          rd_fire;
    logic          tx_push;
    logic          tx_pop;
    logic          rx_push;
    logic          rx_pop;
    logic          addr_ok;
    logic [31:0]   rd_word;
    logic [7:0]    addr;

    assign addr    = 8'(paddr_i);
    assign capture = psel_i & penable_i & ~pready_o;
    assign fire    = psel_i & penable_i & pready_o;
    assign wr_fire = fire & pwrite_i;
    assign rd_fire = fire & ~pwrite_i;

    // Pushes into a full buffer are silently dropped
    assign tx_push = wr_fire && addr == sfb_pkg::OFS_TX_DATA
                     && tx_cnt_r != FULL_CNT;
    assign tx_pop  = tx_pop_i & tx_valid_o;
    assign rx_push = rx_push_i & rx_ready_o;
    assign rx_pop  = rd_fire && addr == sfb_pkg::OFS_RX_DATA && rx_take_r;

    assign tx_cnt_nxt = tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
    assign rx_cnt_nxt = rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
    assign tx_rd_nxt  = tx_rd_r + PW'(tx_pop);
    assign rx_rd_nxt  = rx_rd_r + PW'(rx_pop);
    assign tx_free    = FULL_CNT - tx_cnt_r;

    // Transmit buffer: software fills, serial engine drains
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_cnt_r <= '0;
            tx_wr_r  <= '0;
            tx_rd_r  <= '0;
        end
        else
        begin
            tx_cnt_r <= tx_cnt_nxt;
            tx_rd_r  <= tx_rd_nxt;
            if (tx_push)
            begin
                tx_wr_r <= tx_wr_r + PW'(1);
            end
        end
    end

    // Valid only once the word is readable from the registered RAM port
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_valid_o <= 1'b0;
        end
        else
        begin
            tx_valid_o <= (tx_cnt_r - CW'(tx_pop)) != '0;
        end
    end

    word_ram #(
        .W      (32),
        .DEPTH  (DEPTH),
        .AW     (PW)
    ) u_tx_ram (
        .mclk_i  (mclk_i),
        .we_i    (tx_push),
        .waddr_i (tx_wr_r),
        .wdata_i (pwdata_i),
        .raddr_i (tx_rd_nxt),
        .rdata_o (tx_data_o)
    );

    // Receive buffer: serial engine fills, software drains
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            rx_cnt_r   <= '0;
            rx_wr_r    <= '0;
            rx_rd_r    <= '0;
            rx_ready_o <= 1'b0;
            rx_avail_r <= 1'b0;
        end
        else
        begin
            rx_cnt_r   <= rx_cnt_nxt;
            rx_rd_r    <= rx_rd_nxt;
            rx_ready_o <= rx_cnt_nxt != FULL_CNT;
            rx_avail_r <= (rx_cnt_r - CW'(rx_pop)) != '0;
            if (rx_push)
            begin
                rx_wr_r <= rx_wr_r + PW'(1);
            end
        end
    end

    word_ram #(
        .W      (32),
        .DEPTH  (DEPTH),
        .AW     (PW)
    ) u_rx_ram (
        .mclk_i  (mclk_i),
        .we_i    (rx_push),
        .waddr_i (rx_wr_r),
        .wdata_i (rx_data_i),
        .raddr_i (rx_rd_nxt),
        .rdata_o (rx_rdata)
    );

    // Threshold levels
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_lvl_r <= sfb_pkg::TX_LVL_RST;
            rx_lvl_r <= sfb_pkg::RX_LVL_RST;
        end
        else if (wr_fire && addr == sfb_pkg::OFS_CTRL)
        begin
            tx_lvl_r <= pwdata_i[sfb_pkg::TX_LVL_LSB +: CW];
            rx_lvl_r <= pwdata_i[sfb_pkg::RX_LVL_LSB +: CW];
        end
    end

    // Strap sampled during synchronous reset, released by any bus read
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            boot_hold_r <= boot_xip_i;
        end
        else if (rd_fire)
        begin
            boot_hold_r <= 1'b0;
        end
    end

    // Flag sources are levels; they re-set while the condition holds
    always_comb
    begin
        flag_set = '0;
        flag_set[sfb_pkg::FLG_TX_EMPTY] = tx_cnt_r == '0;
        flag_set[sfb_pkg::FLG_TX_FULL]  = tx_free == '0;
        flag_set[sfb_pkg::FLG_TX_THR]   = tx_free > tx_lvl_r;
        flag_set[sfb_pkg::FLG_RX_THR]   = rx_cnt_r > rx_lvl_r
                                          || boot_hold_r;
    end

    assign flag_clr = (wr_fire && addr == sfb_pkg::OFS_IRQ_FLAGS)
                      ? pwdata_i[NF-1:0] : '0;

    sticky_flags #(
        .N (NF)
    ) u_flags (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .set_i   (flag_set),
        .clr_i   (flag_clr),
        .flags_o (flag_q)
    );

    // Read mux
    always_comb
    begin
        rd_word = '0;
        addr_ok = 1'b1;
        unique case (addr)
            sfb_pkg::OFS_IRQ_FLAGS:
            begin
                rd_word[NF-1:0] = flag_q;
            end
            sfb_pkg::OFS_LEVELS:
            begin
                rd_word[sfb_pkg::TX_FREE_LSB +: CW] = tx_free;
                rd_word[sfb_pkg::RX_CNT_LSB +: CW]  = rx_cnt_r;
            end
            sfb_pkg::OFS_CTRL:
            begin
                rd_word[sfb_pkg::TX_LVL_LSB +: CW] = tx_lvl_r;
                rd_word[sfb_pkg::RX_LVL_LSB +: CW] = rx_lvl_r;
            end
            sfb_pkg::OFS_TX_DATA:
            begin
                rd_word = '0;
            end
            sfb_pkg::OFS_RX_DATA:
            begin
                rd_word = rx_avail_r ? rx_rdata : '0;
            end
            default:
            begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // One wait state: data captured in the first access cycle
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= '0;
            pslverr_o <= 1'b0;
            rx_take_r <= 1'b0;
        end
        else if (capture)
        begin
            pready_o  <= 1'b1;
            prdata_o  <= pwrite_i ? '0 : rd_word;
            pslverr_o <= ~addr_ok;
            rx_take_r <= ~pwrite_i && rx_avail_r
                         && addr == sfb_pkg::OFS_RX_DATA;
        end
        else
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            rx_take_r <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    // Sampled reset in the antecedent: the release edge still resets flags
    a_tx_thr_set: assert property (
        !rst_i && tx_free > tx_lvl_r |=> flag_q[sfb_pkg::FLG_TX_THR])
        else $error("tx threshold flag not set");

    a_tx_full_set: assert property (
        tx_cnt_r == FULL_CNT |=> flag_q[sfb_pkg::FLG_TX_FULL]
            && tx_cnt_r == FULL_CNT - CW'($past(tx_pop)))
        else $error("tx full flag or count wrong");

    a_tx_empty_clr: assert property (
        (flag_clr[sfb_pkg::FLG_TX_EMPTY] && tx_cnt_r != '0)
            |=> !flag_q[sfb_pkg::FLG_TX_EMPTY])
        else $error("tx empty flag stuck");

    a_tx_empty_set: assert property (
        !rst_i && tx_cnt_r == '0 |=> flag_q[sfb_pkg::FLG_TX_EMPTY])
        else $error("tx empty flag not set");

    a_w1c_zero_keep: assert property (
        (wr_fire && addr == sfb_pkg::OFS_IRQ_FLAGS
            && pwdata_i[NF-1:0] == '0)
            |=> (flag_q & $past(flag_q)) == $past(flag_q))
        else $error("flag lost on zero write");

    a_boot_hold: assert property (
        !rst_i && boot_hold_r |=> flag_q[sfb_pkg::FLG_RX_THR]
            && (boot_hold_r || $past(rd_fire)))
        else $error("boot receive flag not held");

    a_free_field: assert property (
        (capture && !pwrite_i && addr == sfb_pkg::OFS_LEVELS)
            |=> pready_o
            && prdata_o[sfb_pkg::TX_FREE_LSB +: CW] == $past(tx_free))
        else $error("free word field wrong");

    a_rx_cnt_field: assert property (
        (capture && !pwrite_i && addr == sfb_pkg::OFS_LEVELS)
            |=> prdata_o[sfb_pkg::RX_CNT_LSB +: CW] == $past(rx_cnt_r)
            && prdata_o[15:CW] == '0)
        else $error("receive count field wrong");

endmodule : serial_flash_buffer_status

`default_nettype wire

// >>> sim/flash_engine_model.sv
`timescale 1ns/1ns
`default_nettype none

module flash_engine_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        tx_valid_i,
    input  wire logic [31:0] tx_data_i,
    input  wire logic        rx_ready_i,
    input  wire logic        pop_en_i,
    input  wire logic [5:0]  push_target_i,
    output var  logic        tx_pop_o,
    output var  logic        rx_push_o,
    output var  logic [31:0] rx_data_o,
    output var  logic [5:0]  pop_count_o,
    output var  logic [31:0] pop_first_o,
    output var  logic [31:0] pop_last_o,
    output var  logic        push_done_o
);
    localparam logic [31:0] RX_BASE = 32'ha5000000;

    logic [5:0] pushed_r;
    logic [5:0] pushed_nxt;

    assign pushed_nxt  = pushed_r + {5'h00, rx_push_o & rx_ready_i};
    assign push_done_o = (pushed_r == push_target_i);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            tx_pop_o    <= 1'b0;
            rx_push_o   <= 1'b0;
            rx_data_o   <= 32'h5a5a5a5a;
            pushed_r    <= 6'h00;
            pop_count_o <= 6'h00;
            pop_first_o <= 32'h00000000;
            pop_last_o  <= 32'h00000000;
        end
        else
        begin
            tx_pop_o <= pop_en_i;
            if (tx_pop_o && tx_valid_i)
            begin
                if (pop_count_o == 6'h00)
                    pop_first_o <= tx_data_i;
                pop_last_o  <= tx_data_i;
                pop_count_o <= pop_count_o + 6'h01;
            end
            pushed_r  <= pushed_nxt;
            rx_push_o <= (pushed_nxt < push_target_i);
            // Idle data line toggles so stale words cannot pass
            if (pushed_nxt < push_target_i)
                rx_data_o <= RX_BASE + {26'h0, pushed_nxt};
            else
                rx_data_o <= ~rx_data_o;
        end
    end
endmodule : flash_engine_model

`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        boot_xip_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_pop;
    logic [31:0] tx_data;
    logic        tx_valid;
    logic        rx_push;
    logic [31:0] rx_data;
    logic        rx_ready;
    logic        pop_en = 1'b0;
    logic [5:0]  push_target = 6'h00;
    logic [5:0]  pop_count;
    logic [31:0] pop_first;
    logic [31:0] pop_last;
    logic        push_done;
    logic [31:0] rd_v;
    logic        err_v;
    int          fail_count = 0;
    int          comparisons = 0;
    int          n;

    initial forever #5 mclk_i = ~mclk_i;

    serial_flash_buffer_status u_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .boot_xip_i(boot_xip_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_pop_i(tx_pop),
        .tx_data_o(tx_data), .tx_valid_o(tx_valid), .rx_push_i(rx_push),
        .rx_data_i(rx_data), .rx_ready_o(rx_ready)
    );

    flash_engine_model u_engine (
        .mclk_i(mclk_i), .rst_i(rst_i), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .rx_ready_i(rx_ready), .pop_en_i(pop_en),
        .push_target_i(push_target), .tx_pop_o(tx_pop),
        .rx_push_o(rx_push), .rx_data_o(rx_data),
        .pop_count_o(pop_count), .pop_first_o(pop_first),
        .pop_last_o(pop_last), .push_done_o(push_done)
    );

    task final_report;
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge mclk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk_i);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            fail_count++;
            final_report();
        end
        rd_v  = prdata;
        err_v = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task chk_rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd_v, exp)
    endtask : chk_rd

    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h0000000d);
        wr(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000000);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h0000000d);
        wr(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000008);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000005);
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200000);
        // One word past capacity; it must be dropped
        for (int i = 0; i < 33; i++)
            wr(sfb_pkg::OFS_TX_DATA, 32'h10000000 + i);
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00000000);
        wr(sfb_pkg::OFS_IRQ_FLAGS, 32'h0000000f);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000002);
        pop_en <= 1'b1;
        for (n = 0; n < 200 && pop_count != 6'd32; n++)
            @(posedge mclk_i);
        pop_en <= 1'b0;
        if (n >= 200)
        begin
            fail_count++;
            final_report();
        end
        `CHK(pop_count, 6'd32)
        `CHK(pop_first, 32'h10000000)
        `CHK(pop_last, 32'h1000001f)
        `CHK(tx_valid, 1'b0)
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200000);
        wr(sfb_pkg::OFS_CTRL, 32'h00000020);
        wr(sfb_pkg::OFS_IRQ_FLAGS, 32'h0000000f);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000001);
        wr(sfb_pkg::OFS_CTRL, 32'h0000001f);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000005);
        push_target <= 6'd3;
        // Done is true before the new target reaches the model
        @(posedge mclk_i);
        for (n = 0; n < 50 && push_done !== 1'b1; n++)
            @(posedge mclk_i);
        if (n >= 50)
        begin
            fail_count++;
            final_report();
        end
        `CHK(rx_ready, 1'b1)
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200003);
        chk_rd(sfb_pkg::OFS_RX_DATA, 32'ha5000000);
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200002);
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h0000000d);
        wr(sfb_pkg::OFS_LEVELS, 32'hffffffff);
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200002);
        chk_rd(8'h14, 32'h00000000);
        `CHK(err_v, 1'b1)
        // Second reset without the boot strap: no held receive flag
        boot_xip_i  <= 1'b0;
        push_target <= 6'h00;
        rst_i       <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk_rd(sfb_pkg::OFS_IRQ_FLAGS, 32'h00000005);
        chk_rd(sfb_pkg::OFS_LEVELS, 32'h00200000);
        final_report();
    end
endmodule : tb_top

`default_nettype wire
